//--- jlts_pkg.sv
// Function
// R01 - Modes 000/001/010: samples, D21.5, K28.5
// R02 - Mode 011 repeats K28.5 and alignment
// R03 - Mode 100 sends 12-octet RPAT
// R04 - Disparity flip only in mode 100
// R05 - Pulse select governs SYSREF/SYNC handling
// R06 - Bit2=0, bit0=0: every pulse resets dividers
// R07 - Bit2=1, bit0=0: no divider reset
// R08 - Bit0=1: one pulse after bit1 rises
// R09 - SYSREF resets multiframe counter to zero
// R10 - K28.5 stops when counter reaches 31
// R11 - Force bit reloads programmed start value
// R12 - Software sets force bit for start value
// R13 - Alignment delayed 0..3 multiframes
// R14 - Subclass codes 000, 001, 010
// R15 - Undefined pattern codes give normal data
package jlts_pkg;
	localparam logic [7:0] OFS_SUBCLASS = 8'h34;
	localparam logic [7:0] OFS_TEST_PULSE = 8'h3b;
	localparam logic [7:0] OFS_MF_CTRL = 8'h3c;
	localparam logic [7:0] OFS_STATUS = 8'h3d;
	localparam logic [7:0] RST_SUBCLASS = 8'h00;
	localparam logic [7:0] RST_TEST_PULSE = 8'h00;
	localparam logic [7:0] RST_MF_CTRL = 8'h00;
	// Field positions
	localparam int TP_MODE_LSB = 5;
	localparam int TP_FLIP_BIT = 4;
	localparam int SC_LSB = 5;
	localparam int MF_FORCE_BIT = 7;
	localparam int MF_START_LSB = 2;
	// Codes
	localparam logic [2:0] TM_NORMAL = 3'h0;
	localparam logic [2:0] TM_D215 = 3'h1;
	localparam logic [2:0] TM_K285 = 3'h2;
	localparam logic [2:0] TM_REPEAT_ILA = 3'h3;
	localparam logic [2:0] TM_RPAT = 3'h4;
	localparam logic [2:0] SC_0 = 3'h0;
	localparam logic [2:0] SC_1 = 3'h1;
	localparam logic [2:0] SC_2 = 3'h2;
	// Characters
	localparam logic [7:0] CH_K285 = 8'hbc;
	localparam logic [7:0] CH_K280 = 8'h1c;
	localparam logic [7:0] CH_K283 = 8'h7c;
	localparam logic [7:0] CH_D215 = 8'hb5;
	// Counts
	localparam logic [4:0] LMFC_LAST = 5'h1f;
	localparam logic [1:0] ILA_LAST_MF = 2'h3;
	localparam logic [3:0] RPAT_LAST = 4'hb;
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_WIDTH = 8;
	typedef enum logic [1:0] {ST_CGS, ST_HOLD, ST_ILA, ST_DATA} jlts_state_e;
	typedef logic [7:0] jlts_rpat_t [12];
	localparam jlts_rpat_t RPAT_TABLE = '{8'hbe, 8'hd7, 8'h23, 8'h47,
		8'h6b, 8'h8f, 8'hb3, 8'h14, 8'h5e, 8'hfb, 8'h35, 8'h59};
endpackage

//--- jlts_lane_if.sv
`timescale 1ns/1ps
`default_nettype none
interface jlts_lane_if;
	import jlts_pkg::*;
	jlts_state_e state;
	logic [2:0] mode;
	logic [4:0] lmfc;
	logic [3:0] rpat_idx;
	logic smp_valid;
	logic [7:0] smp;
	logic [7:0] octet;
	logic is_k;
	modport ctl (output state, mode, lmfc, rpat_idx, smp_valid, smp,
		input octet, is_k);
	modport gen (input state, mode, lmfc, rpat_idx, smp_valid, smp,
		output octet, is_k);
endinterface
`default_nettype wire

//--- jlts_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module jlts_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk, // Core clock
	input wire logic rst, // Async reset
	input wire logic in_valid, // Write offered
	output logic in_ready, // Room left
	input wire logic [WIDTH-1:0] in_data, // Write word
	output logic out_valid, // Word waiting
	input wire logic out_ready, // Consumer takes
	output logic [WIDTH-1:0] out_data // Head word
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp_q, rp_q;
	logic [AW:0] cnt_q;
	logic full_q;
	logic wr, rd;
	assign wr = in_valid && !full_q;
	assign rd = out_ready && (cnt_q != '0);
	assign in_ready = !full_q;
	assign out_valid = (cnt_q != '0);
	assign out_data = mem[rp_q];
	// Storage has no reset; only pointers matter
	always_ff @(posedge clk) begin
		if (wr) begin
			mem[wp_q] <= in_data;
		end
	end
	// Pointers and occupancy
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
			full_q <= 1'b0;
		end else begin
			if (wr) wp_q <= wp_q + AW'(1);
			if (rd) rp_q <= rp_q + AW'(1);
			cnt_q <= cnt_q + (AW+1)'(wr) - (AW+1)'(rd);
			full_q <= (cnt_q + (AW+1)'(wr) - (AW+1)'(rd)) == (AW+1)'(DEPTH);
		end
	end
	fifo_full_a: assert property (@(posedge clk) disable iff (rst)
		full_q |-> cnt_q == (AW+1)'(DEPTH))
		else $error("fifo full flag without full count");
endmodule
`default_nettype wire

//--- jlts_patgen.sv
`timescale 1ns/1ps
`default_nettype none
module jlts_patgen
	import jlts_pkg::*;
(
	jlts_lane_if.gen lane // Pattern request and octet
);
	// Test patterns override the link state; repeat mode and undefined codes fall through
	always_comb begin
		lane.octet = CH_K285;
		lane.is_k = 1'b1;
		unique case (lane.mode)
			TM_D215: begin // R01
				lane.octet = CH_D215;
				lane.is_k = 1'b0;
			end
			TM_K285: begin // R01
				lane.octet = CH_K285;
				lane.is_k = 1'b1;
			end
			TM_RPAT: begin // R03
				lane.octet = RPAT_TABLE[lane.rpat_idx];
				lane.is_k = 1'b0;
			end
			default: begin // R15
				unique case (lane.state)
					ST_CGS, ST_HOLD: begin // R02
						lane.octet = CH_K285;
						lane.is_k = 1'b1;
					end
					ST_ILA: begin
						// Multiframe start and end marks, ramp between
						lane.is_k = (lane.lmfc == '0) || (lane.lmfc == LMFC_LAST);
						lane.octet = (lane.lmfc == '0) ? CH_K280 :
							(lane.lmfc == LMFC_LAST) ? CH_K283 : {3'h0, lane.lmfc};
					end
					ST_DATA: begin // R01
						lane.octet = lane.smp_valid ? lane.smp : 8'h00;
						lane.is_k = 1'b0;
					end
				endcase
			end
		endcase
	end
endmodule
`default_nettype wire

//--- jlts_top.sv
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module jlts_top
	import jlts_pkg::*;
(
	input wire logic CORE_CLK, // 20 MHz core clock
	input wire logic RST, // Async reset, high
	input wire logic [7:0] ADDR, // Register address
	input wire logic [7:0] WR_DATA, // Write data
	input wire logic WR_EN, // Write strobe
	input wire logic RD_EN, // Read strobe
	output logic [7:0] RD_DATA, // Read data, next cycle
	input wire logic SYSREF_IN, // SYSREF pin
	input wire logic SYNC_N_IN, // Receiver sync request, low
	input wire logic SMP_VALID, // Sample offered
	output logic SMP_READY, // FIFO has room
	input wire logic [7:0] SMP_DATA, // Sample octet
	output logic [7:0] LANE_OCTET, // Octet to encoder
	output logic LANE_CTRL, // Octet is a K character
	output logic LANE_DISP_FLIP, // Invert running disparity
	output logic DIV_RESET // Clock divider reset pulse
);
	logic [7:0] sc_q, tp_q, mf_q;
	logic [2:0] mode, pd;
	logic flip;
	logic sr1_q, sr2_q, sr3_q, sy1_q, sy2_q, sy3_q;
	logic pulse, allow, arm_q;
	logic [4:0] lmfc_q, lmfc_d;
	jlts_state_e st_q;
	logic [1:0] hold_q, ila_q;
	logic [3:0] rpat_q;
	logic mf_end, sync_ok;
	logic fifo_valid, fifo_pop, fifo_room;
	logic [7:0] fifo_data;
	jlts_lane_if lane ();

	assign mode = tp_q[TP_MODE_LSB +: 3];
	assign flip = tp_q[TP_FLIP_BIT];
	assign pd = tp_q[2:0];
	assign mf_end = (lmfc_q == LMFC_LAST);

	// Register writes; reserved bit 3 of the test register stays zero
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			sc_q <= RST_SUBCLASS;
			tp_q <= RST_TEST_PULSE;
			mf_q <= RST_MF_CTRL;
		end else if (WR_EN) begin
			unique case (ADDR)
				OFS_SUBCLASS: sc_q <= {WR_DATA[7:5], 5'h00};
				OFS_TEST_PULSE: tp_q <= {WR_DATA[7:4], 1'b0, WR_DATA[2:0]};
				OFS_MF_CTRL: mf_q <= WR_DATA;
				default: ;
			endcase
		end
	end

	// Read mux, registered so data stand one cycle later
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			RD_DATA <= 8'h00;
		end else if (RD_EN) begin
			unique case (ADDR)
				OFS_SUBCLASS: RD_DATA <= sc_q;
				OFS_TEST_PULSE: RD_DATA <= tp_q;
				OFS_MF_CTRL: RD_DATA <= mf_q;
				OFS_STATUS: RD_DATA <= {1'b0, st_q, lmfc_q};
				default: RD_DATA <= 8'h00;
			endcase
		end else begin
			RD_DATA <= 8'h00;
		end
	end

	// Pin synchronisers; third stage only for edge detection
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			sr1_q <= 1'b0;
			sr2_q <= 1'b0;
			sr3_q <= 1'b0;
			sy1_q <= 1'b0;
			sy2_q <= 1'b0;
			sy3_q <= 1'b0;
		end else begin
			sr1_q <= SYSREF_IN;
			sr2_q <= sr1_q;
			sr3_q <= sr2_q;
			sy1_q <= SYNC_N_IN;
			sy2_q <= sy1_q;
			sy3_q <= sy2_q;
		end
	end
	assign sync_ok = sy2_q || (mode == TM_REPEAT_ILA);

	// Pulse source follows subclass: SYSREF rise or SYNC fall
	always_comb begin
		unique case (sc_q[SC_LSB +: 3]) // R14 R05
			SC_1: pulse = sr2_q && !sr3_q;
			SC_2: pulse = !sy2_q && sy3_q;
			default: pulse = 1'b0;
		endcase
	end

	// Divider gating; one-shot armed by a 0-to-1 write of bit 1
	always_comb begin
		if (pd[0]) begin
			allow = arm_q; // R08
		end else begin
			allow = !pd[2]; // R06 R07
		end
	end

	// Arm flag: the write's rise beats a same-cycle consuming pulse
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			arm_q <= 1'b0;
		end else if (WR_EN && ADDR == OFS_TEST_PULSE && WR_DATA[1]
			&& !tp_q[1]) begin
			arm_q <= 1'b1; // R08
		end else if (pulse && pd[0]) begin
			arm_q <= 1'b0; // R08
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			DIV_RESET <= 1'b0;
		end else begin
			DIV_RESET <= pulse && allow; // R06 R07 R08
		end
	end

	// Multiframe counter; accepted pulse reloads zero or the start value
	always_comb begin
		lmfc_d = lmfc_q + 5'h01;
		if (pulse && allow) begin
			lmfc_d = mf_q[MF_FORCE_BIT] ? mf_q[MF_START_LSB +: 5] : 5'h00; // R09 R11 R12
		end
	end
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			lmfc_q <= 5'h00;
		end else begin
			lmfc_q <= lmfc_d;
		end
	end

	// Link sequencing: CGS, optional hold, four ILA multiframes, data
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			st_q <= ST_CGS;
			hold_q <= 2'h0;
			ila_q <= 2'h0;
		end else begin
			unique case (st_q)
				ST_CGS: begin
					if (sync_ok && mf_end) begin // R10
						hold_q <= mf_q[1:0];
						ila_q <= 2'h0;
						st_q <= (mf_q[1:0] == 2'h0) ? ST_ILA : ST_HOLD; // R13
					end
				end
				ST_HOLD: begin
					if (!sync_ok) begin
						st_q <= ST_CGS;
					end else if (mf_end) begin
						hold_q <= hold_q - 2'h1;
						if (hold_q == 2'h1) st_q <= ST_ILA; // R13
					end
				end
				ST_ILA: begin
					if (!sync_ok) begin
						st_q <= ST_CGS;
					end else if (mf_end) begin
						ila_q <= ila_q + 2'h1;
						if (ila_q == ILA_LAST_MF) begin
							// Repeat mode loops back instead of sending data
							st_q <= (mode == TM_REPEAT_ILA) ? ST_CGS : ST_DATA; // R02
						end
					end
				end
				ST_DATA: begin
					// Repeat mode set while data flows restarts alignment
					if (!sync_ok || mode == TM_REPEAT_ILA) begin
						st_q <= ST_CGS; // R02
					end
				end
			endcase
		end
	end

	// RPAT octet index, restarts whenever the mode is left
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			rpat_q <= 4'h0;
		end else if (mode != TM_RPAT || rpat_q == RPAT_LAST) begin
			rpat_q <= 4'h0; // R03
		end else begin
			rpat_q <= rpat_q + 4'h1;
		end
	end

	// Samples drain only while real data goes out, so the FIFO backs up
	assign fifo_pop = (st_q == ST_DATA) && (mode != TM_D215)
		&& (mode != TM_K285) && (mode != TM_RPAT);
	jlts_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(CORE_CLK),
		.rst(RST),
		.in_valid(SMP_VALID),
		.in_ready(fifo_room),
		.in_data(SMP_DATA),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data)
	);
	// Registered copy of the FIFO's room flag, the inverse of its registered full flag, lagging a cycle
	logic room_q;
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			room_q <= 1'b0;
		end else begin
			room_q <= fifo_room;
		end
	end
	assign SMP_READY = room_q;

	assign lane.state = st_q;
	assign lane.mode = mode;
	assign lane.lmfc = lmfc_q;
	assign lane.rpat_idx = rpat_q;
	assign lane.smp_valid = fifo_valid && fifo_pop;
	assign lane.smp = fifo_data;
	jlts_patgen u_gen (
		.lane(lane.gen)
	);

	// Lane outputs registered; flip only honoured in RPAT mode
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			LANE_OCTET <= CH_K285;
			LANE_CTRL <= 1'b1;
			LANE_DISP_FLIP <= 1'b0;
		end else begin
			LANE_OCTET <= lane.octet;
			LANE_CTRL <= lane.is_k;
			LANE_DISP_FLIP <= flip && (mode == TM_RPAT); // R04
		end
	end

	sequence cgs_done_s;
		st_q == ST_CGS && sync_ok && mf_end && mf_q[1:0] == 2'h0;
	endsequence
	sequence hold_done_s;
		st_q == ST_HOLD && sync_ok && mf_end && hold_q == 2'h1;
	endsequence
	sequence accepted_s;
		pulse && allow;
	endsequence

	pat_d215_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R01
		mode == TM_D215 |=> LANE_OCTET == CH_D215 && !LANE_CTRL)
		else $error("D21.5 pattern not sent");
	pat_k285_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R01
		mode == TM_K285 |=> LANE_OCTET == CH_K285 && LANE_CTRL)
		else $error("K28.5 pattern not sent");
	ila_repeat_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R02
		st_q == ST_ILA && mf_end && ila_q == ILA_LAST_MF
		&& mode == TM_REPEAT_ILA |=> st_q == ST_CGS)
		else $error("repeat mode entered data");
	rpat_start_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R03
		mode == TM_RPAT && rpat_q == 4'h0 ##1 mode == TM_RPAT
		|-> LANE_OCTET == RPAT_TABLE[0] ##1 LANE_OCTET == RPAT_TABLE[1])
		else $error("RPAT order wrong");
	flip_gate_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R04
		LANE_DISP_FLIP |-> $past(mode) == TM_RPAT && $past(flip))
		else $error("disparity flip outside RPAT");
	div_all_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R06
		pulse && !pd[2] && !pd[0] |=> DIV_RESET)
		else $error("pulse did not reset divider");
	div_never_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R07
		pd[2] && !pd[0] |=> !DIV_RESET)
		else $error("divider reset while blocked");
	div_once_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R08
		DIV_RESET && $past(pd[0]) && !$past(arm_q, 2) |-> $past(arm_q))
		else $error("one-shot reset without arming");
	lmfc_load_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R09 R11
		accepted_s |=> lmfc_q == ($past(mf_q[MF_FORCE_BIT])
		? $past(mf_q[MF_START_LSB +: 5]) : 5'h00))
		else $error("multiframe counter reload wrong");
	cgs_end_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R10
		cgs_done_s |=> st_q == ST_ILA)
		else $error("alignment not started at count 31");
	hold_end_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R13
		hold_done_s |=> st_q == ST_ILA)
		else $error("alignment delay wrong");
	undef_mode_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R15
		st_q == ST_DATA && mode[2] && mode[1:0] != 2'h0 |=> !LANE_CTRL)
		else $error("undefined mode sent control");
	data_repeat_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R02
		st_q == ST_DATA && mode == TM_REPEAT_ILA |=> st_q == ST_CGS)
		else $error("repeat mode kept sending data");
	// Read data must not linger outside its one-cycle slot
	rd_idle_a: assert property (@(posedge CORE_CLK) disable iff (RST)
		!RD_EN |=> RD_DATA == 8'h00)
		else $error("read data outside read slot");
	// A pulse in one-shot mode spends the arm flag the next cycle, unless a write comes with it
	arm_spent_a: assert property (@(posedge CORE_CLK) disable iff (RST) // R08
		pulse && pd[0] && !WR_EN |=> !arm_q)
		else $error("one-shot not spent by pulse");
endmodule
`default_nettype wire

//--- jlts_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
// Lane receiver: requests sync until it trusts the K28.5 stream
module jlts_rx_model (
	input wire logic clk, // Core clock
	input wire logic rst, // Reset, high
	input wire logic [7:0] octet, // Lane octet
	input wire logic ctrl, // Octet is K
	input wire logic resync, // Force a new sync request
	output logic sync_n, // Sync request, low
	output logic link_up // Four alignment frames seen
);
	logic [1:0] k_cnt;
	logic [2:0] end_cnt;
	// Four K28.5 in a row before release, so one stray octet is not trusted
	always_ff @(posedge clk or posedge rst) begin
		if (rst || resync) begin
			sync_n <= 1'b0;
			k_cnt <= 2'h0;
			end_cnt <= 3'h0;
		end else if (!sync_n) begin
			if (ctrl && octet == 8'hbc)
				k_cnt <= k_cnt + 2'h1;
			else
				k_cnt <= 2'h0;
			if (ctrl && octet == 8'hbc && k_cnt == 2'h3)
				sync_n <= 1'b1;
		end else if (ctrl && octet == 8'h7c && end_cnt != 3'h4) begin
			end_cnt <= end_cnt + 3'h1;
		end
	end
	// Up once every alignment frame has closed
	assign link_up = end_cnt == 3'h4;
endmodule
`default_nettype wire

//--- tb_jesd_link_test_and_lmfc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module tb_jesd_link_test_and_lmfc_sync
	import jlts_pkg::*;
();
	logic clk, rst, wr, rd, sysref, smp_v, smp_rdy, resync;
	logic ctl, flip, divr, sync_n, link_up;
	logic [7:0] addr, wdat, rdat, smp_d, oct, v, v0;
	int mismatches, num_checks, t, i, per0, per;
	// Rows: register value, octet, {ctrl, flip}
	logic [23:0] rows [7] = '{24'h000000, 24'h30b500, 24'h40bc02,
		24'hb00000, 24'hc00000, 24'he00000, 24'h100000};

	jlts_top DUT (.CORE_CLK(clk), .RST(rst), .ADDR(addr), .WR_DATA(wdat),
		.WR_EN(wr), .RD_EN(rd), .RD_DATA(rdat), .SYSREF_IN(sysref),
		.SYNC_N_IN(sync_n), .SMP_VALID(smp_v), .SMP_READY(smp_rdy),
		.SMP_DATA(smp_d), .LANE_OCTET(oct), .LANE_CTRL(ctl),
		.LANE_DISP_FLIP(flip), .DIV_RESET(divr));
	jlts_rx_model u_rx (.clk(clk), .rst(rst), .octet(oct), .ctrl(ctl),
		.resync(resync), .sync_n(sync_n), .link_up(link_up));

	// Core clock, 50 ns period
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] want);
		num_checks++;
		if (got !== want) begin
			mismatches++;
			$display("wrong value at %0t: got %h want %h", $time, got, want);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdat <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdat;
	endtask
	// One SYSREF or sync drop, then count divider resets
	task automatic pulse(input bit use_sync, input int want);
		int n;
		n = 0;
		@(posedge clk);
		if (use_sync)
			resync <= 1'b1;
		else
			sysref <= 1'b1;
		@(posedge clk);
		resync <= 1'b0;
		sysref <= 1'b0;
		repeat (12) begin
			@(posedge clk);
			#1;
			if (divr === 1'b1)
				n++;
		end
		chk(8'(n), 8'(want));
	endtask
	// Same timing every call, so counter reads compare directly
	task automatic mf_read(input logic [7:0] mf, output logic [7:0] c);
		wr_reg(OFS_MF_CTRL, mf);
		pulse(1'b0, 1);
		rd_reg(OFS_STATUS, c);
		c = c & 8'h1f;
	endtask
	task automatic wait_up;
		for (t = 0; t < 3000 && link_up !== 1'b1; t++)
			@(posedge clk);
		#1;
		chk({7'h0, link_up}, 8'h01);
	endtask
	// Cycles between the second and third alignment starts
	task automatic ila_per(input logic [7:0] dly, output int p);
		logic [7:0] pv;
		logic st;
		int t0, k;
		wr_reg(OFS_MF_CTRL, dly);
		pv = 8'h00;
		t0 = 0;
		p = 0;
		k = 0;
		for (t = 0; t < 3000 && k < 3; t++) begin
			@(posedge clk);
			#1;
			st = ctl === 1'b1 && oct === CH_K280;
			if (st && pv !== CH_K283) begin
				k++;
				if (k == 2)
					t0 = t;
				if (k == 3)
					p = t - t0;
			end
			pv = oct;
		end
	endtask

	initial begin
		rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		sysref = 1'b0;
		smp_v = 1'b0;
		resync = 1'b0;
		addr = 8'h00;
		wdat = 8'h00;
		smp_d = 8'h00;
		mismatches = 0;
		num_checks = 0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		// Reset values, masked bit, unmapped place
		rd_reg(OFS_SUBCLASS, v);
		chk(v, RST_SUBCLASS);
		rd_reg(OFS_TEST_PULSE, v);
		chk(v, RST_TEST_PULSE);
		rd_reg(OFS_MF_CTRL, v);
		chk(v, RST_MF_CTRL);
		wr_reg(OFS_TEST_PULSE, 8'hf8);
		rd_reg(OFS_TEST_PULSE, v);
		chk(v, 8'hf0);
		wr_reg(8'h50, 8'h5a);
		rd_reg(8'h50, v);
		chk(v, 8'h00);
		$display("test registers done");
		wait_up();
		foreach (rows[j]) begin
			wr_reg(OFS_TEST_PULSE, rows[j][23:16]);
			cyc(3);
			#1;
			chk(oct, rows[j][15:8]);
			chk({6'h0, ctl, flip}, rows[j][7:0]);
		end
		$display("test modes done");
		// Pattern with flip, twice through the table
		wr_reg(OFS_TEST_PULSE, 8'h90);
		#1;
		for (t = 0; t < 40 && oct !== RPAT_TABLE[0]; t++) begin
			@(posedge clk);
			#1;
		end
		for (i = 0; i < 24; i++) begin
			chk(oct, RPAT_TABLE[i % 12]);
			@(posedge clk);
			#1;
		end
		chk({7'h0, flip}, 8'h01);
		$display("test pattern done");
		// Lane stalls in a test mode; the seventeenth word must be refused
		wr_reg(OFS_TEST_PULSE, {TM_K285, 5'h00});
		for (i = 0; i < 17; i++) begin
			@(posedge clk);
			smp_d <= 8'h80 + 8'(i);
			smp_v <= 1'b1;
			@(posedge clk);
			smp_v <= 1'b0;
			cyc(2);
		end
		#1;
		chk({7'h0, smp_rdy}, 8'h00);
		wr_reg(OFS_TEST_PULSE, 8'h00);
		#1;
		for (t = 0; t < 40 && oct !== 8'h80; t++) begin
			@(posedge clk);
			#1;
		end
		for (i = 0; i < 17; i++) begin
			chk(oct, i < 16 ? 8'h80 + 8'(i) : 8'h00);
			@(posedge clk);
			#1;
		end
		chk({7'h0, smp_rdy}, 8'h01);
		$display("test buffer done");
		// Counter start: plain, value without force, forced values
		wr_reg(OFS_SUBCLASS, {SC_1, 5'h00});
		mf_read(8'h00, v0);
		mf_read(8'h24, v);
		chk(v, v0);
		mf_read(8'ha4, v);
		chk(v, (v0 + 8'h09) & 8'h1f);
		mf_read(8'hfc, v);
		chk(v, (v0 + 8'h1f) & 8'h1f);
		wr_reg(OFS_MF_CTRL, 8'h00);
		$display("test counter done");
		// Divider gate for each pulse select and subclass
		wr_reg(OFS_TEST_PULSE, 8'h04);
		pulse(1'b0, 0);
		wr_reg(OFS_TEST_PULSE, 8'h01);
		pulse(1'b0, 0);
		wr_reg(OFS_TEST_PULSE, 8'h03);
		pulse(1'b0, 1);
		pulse(1'b0, 0);
		wr_reg(OFS_TEST_PULSE, 8'h00);
		pulse(1'b0, 1);
		wr_reg(OFS_SUBCLASS, {SC_0, 5'h00});
		pulse(1'b0, 0);
		wr_reg(OFS_SUBCLASS, {SC_2, 5'h00});
		pulse(1'b0, 0);
		pulse(1'b1, 1);
		wait_up();
		$display("test divider done");
		// Repeated alignment: one multiframe longer per delay step
		wr_reg(OFS_TEST_PULSE, {TM_REPEAT_ILA, 5'h00});
		ila_per(8'h00, per0);
		chk(8'(per0 % 32), 8'h00);
		chk(8'(per0 > 0), 8'h01);
		for (i = 1; i < 4; i++) begin
			ila_per(8'(i), per);
			chk(8'(per - per0), 8'(32 * i));
		end
		$display("test alignment done");
		print_verdict();
	end

	// Watchdog at 20000 cycles, well past the expected run
	initial begin
		#1000000;
		mismatches++;
		print_verdict();
	end
endmodule
`default_nettype wire
